// file: logic/tpts_touch_pad_turn_sequencer.sv
// Our own choices: the register offsets and the AXI4-Lite slave port.
module tpts_touch_pad_turn_sequencer import tpts_pkg::*; #(
  parameter int PADS = 8,
  parameter int CMP_W = 8,
  parameter int MAX_COLS = 7,
  parameter int CYCLES = SLICE_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Slice outputs
  output logic touchActive,
  output logic columnActive,
  output logic [2:0] activeColumn,
  output logic [2:0] activePad,
  output logic [CMP_W-1:0] internalCompare,
  // Interrupt
  output logic irq
);
  generate
    if (PADS < 2 || PADS > 8 || CMP_W < 1 || CMP_W > 8 || MAX_COLS < 0 || MAX_COLS > 7)
    begin : g_bad
      $error("tpts_touch_pad_turn_sequencer: parameter out of range");
    end
  endgenerate

  localparam logic [2:0] LAST_PAD = 3'(PADS - 1);
  localparam logic [2:0] COL_LIMIT = 3'(MAX_COLS);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding

  function automatic logic isCmp(input logic [ADDR_W-1:0] a);
    isCmp = (a[7:5] == CMP_BLOCK) && ({1'b0, a[4:2]} < 4'(PADS));
  endfunction

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = {a[7:2], 2'b00};
    isMapped = isCmp(a) || w == OFS_CTRL || w == OFS_FUNC || w == OFS_ISTAT
      || w == OFS_IMASK || w == OFS_ICMP;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  tpts_wr_s wrReq;
  logic wrValid;
  logic [ADDR_W-1:0] rdAddr;
  logic [31:0] rdData;
  logic wrErr;
  logic rdErr;

  tpts_axil_slave u_bus (
    .clock(clock),
    .reset_n(reset_n),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wrReq(wrReq),
    .wrValid(wrValid),
    .wrErr(wrErr),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdErr(rdErr)
  );

  logic wrLow;
  logic [ADDR_W-1:0] wrWord;
  assign wrErr = !isMapped(wrReq.addr);
  assign rdErr = !isMapped(rdAddr);
  assign wrLow = wrValid && wrReq.strb[0];
  assign wrWord = {wrReq.addr[7:2], 2'b00};

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic tsEn_q;
  logic swSel_q;
  logic [2:0] numCols_q;
  logic [CMP_W-1:0] cmp_q [PADS];
  logic [1:0] imask_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tsEn_q <= 1'b0;
      swSel_q <= 1'b0;
      numCols_q <= RST_NCOL;
      imask_q <= RST_IRQ;
    end else if (wrLow && wrWord == OFS_CTRL) begin
      tsEn_q <= wrReq.data[CTRL_TSEN];
      swSel_q <= wrReq.data[CTRL_SWSEL];
      numCols_q <= (wrReq.data[CTRL_NCOL_LSB +: 3] > COL_LIMIT) ? COL_LIMIT
        : wrReq.data[CTRL_NCOL_LSB +: 3];
    end else if (wrLow && wrWord == OFS_IMASK) begin
      imask_q <= wrReq.data[1:0];
    end
  end

  // Compare value per pad
  generate
    for (genvar i = 0; i < PADS; i++) begin : g_cmp
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          cmp_q[i] <= '0;
        end else if (wrLow && isCmp(wrReq.addr) && wrReq.addr[4:2] == 3'(i)) begin
          cmp_q[i] <= wrReq.data[CMP_W-1:0];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Slice sequencer

  tpts_seq_e state_q;
  tpts_seq_e stateD;
  logic [2:0] col_q;
  logic [2:0] colD;
  logic sliceEnd;
  logic frameEnd;
  logic enterTouch;

  tpts_slice_timer #(
    .CYCLES(CYCLES)
  ) u_timer (
    .clock(clock),
    .reset_n(reset_n),
    .run(state_q != SQ_IDLE),
    .sliceEnd(sliceEnd)
  );

  // Frame: touch slice, then LED columns 0..n-1
  always_comb begin
    stateD = state_q;
    colD = col_q;
    frameEnd = 1'b0;
    case (state_q)
      SQ_IDLE: begin
        if (tsEn_q) begin
          stateD = SQ_TOUCH;
        end else if (numCols_q != 3'h0) begin
          stateD = SQ_COLUMN;
          colD = 3'h0;
        end
      end
      SQ_TOUCH: begin
        if (sliceEnd) begin
          if (numCols_q != 3'h0) begin
            stateD = SQ_COLUMN;
            colD = 3'h0;
          end else begin
            frameEnd = 1'b1;
            if (!tsEn_q) begin
              stateD = SQ_IDLE;
            end
          end
        end
      end
      SQ_COLUMN: begin
        if (sliceEnd) begin
          if ({1'b0, col_q} + 4'h1 < {1'b0, numCols_q}) begin
            colD = col_q + 3'h1;
          end else begin
            frameEnd = 1'b1;
            colD = 3'h0;
            if (tsEn_q) begin
              stateD = SQ_TOUCH;
            end else if (numCols_q == 3'h0) begin
              stateD = SQ_IDLE;
            end
          end
        end
      end
      default: begin
        stateD = SQ_IDLE;
      end
    endcase
    enterTouch = (stateD == SQ_TOUCH) && (state_q != SQ_TOUCH || sliceEnd);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= SQ_IDLE;
      col_q <= 3'h0;
    end else begin
      state_q <= stateD;
      col_q <= colD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad turn tracking

  logic [2:0] padTurn_q;
  logic pending_q;
  logic hwMode;
  logic [2:0] prevFn_q;
  logic [CMP_W-1:0] intCmp_q;

  assign hwMode = tsEn_q && !swSel_q;

  // Update deferred to the end of the slice after touch-sense
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      padTurn_q <= RST_PAD;
      pending_q <= 1'b0;
    end else if (!hwMode) begin
      pending_q <= 1'b0;
      if (swSel_q && wrLow && wrWord == OFS_FUNC) begin
        padTurn_q <= wrReq.data[FUNC_PAD_LSB +: 3] > LAST_PAD ? RST_PAD
          : wrReq.data[FUNC_PAD_LSB +: 3];
      end
    end else if (sliceEnd) begin
      pending_q <= (state_q == SQ_TOUCH);
      if (pending_q) begin
        padTurn_q <= (padTurn_q == LAST_PAD) ? 3'h0 : padTurn_q + 3'h1;
      end
    end
  end

  // Previous slice function code
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prevFn_q <= RST_PREV_FUNCTION_COLUMN;
    end else if (sliceEnd) begin
      prevFn_q <= (state_q == SQ_TOUCH) ? PREV_FUNCTION_COLUMN_TOUCH : PREV_FUNCTION_COLUMN_COL0 - col_q;
    end
  end

  // Loaded with the index as it stands at slice start
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      intCmp_q <= '0;
    end else if (enterTouch) begin
      intCmp_q <= cmp_q[padTurn_q];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  logic [1:0] istat_q;
  logic [1:0] events;
  logic [1:0] clearBits;

  assign events = {frameEnd, sliceEnd};
  assign clearBits = (wrLow && wrWord == OFS_ISTAT) ? wrReq.data[1:0] : 2'h0;

  // Set wins over a simultaneous clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      istat_q <= RST_IRQ;
    end else begin
      istat_q <= (istat_q & ~clearBits) | events;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((istat_q & ~clearBits | events) & imask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb begin
    rdData = 32'h00000000;
    if (isCmp(rdAddr)) begin
      rdData[CMP_W-1:0] = cmp_q[rdAddr[4:2]];
    end else begin
      case ({rdAddr[7:2], 2'b00})
        OFS_CTRL: begin
          rdData[CTRL_TSEN] = tsEn_q;
          rdData[CTRL_SWSEL] = swSel_q;
          rdData[CTRL_NCOL_LSB +: 3] = numCols_q;
        end
        OFS_FUNC: begin
          rdData[FUNC_PAD_LSB +: 3] = padTurn_q;
          rdData[FUNC_PREV_FUNCTION_COLUMN_LSB +: 3] = prevFn_q;
        end
        OFS_ISTAT: rdData[1:0] = istat_q;
        OFS_IMASK: rdData[1:0] = imask_q;
        OFS_ICMP: rdData[CMP_W-1:0] = intCmp_q;
        default: rdData = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slice outputs

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      touchActive <= 1'b0;
      columnActive <= 1'b0;
      activeColumn <= 3'h0;
      activePad <= RST_PAD;
    end else begin
      touchActive <= (state_q == SQ_TOUCH);
      columnActive <= (state_q == SQ_COLUMN);
      activeColumn <= col_q;
      activePad <= padTurn_q;
    end
  end

  assign internalCompare = intCmp_q;
endmodule

// file: logic/tpts_pkg.sv
package tpts_pkg;
  // Register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FUNC = 8'h04;
  localparam logic [7:0] OFS_ISTAT = 8'h08;
  localparam logic [7:0] OFS_IMASK = 8'h0C;
  localparam logic [7:0] OFS_ICMP = 8'h10;
  localparam logic [7:0] OFS_CMP_BASE = 8'h20;
  localparam logic [2:0] CMP_BLOCK = 3'h1;
  // Field positions
  localparam int CTRL_TSEN = 0;
  localparam int CTRL_SWSEL = 1;
  localparam int CTRL_NCOL_LSB = 4;
  localparam int FUNC_PAD_LSB = 0;
  localparam int FUNC_PREV_FUNCTION_COLUMN_LSB = 4;
  localparam int IRQ_SLICE = 0;
  localparam int IRQ_FRAME = 1;
  // Previous function codes
  localparam logic [2:0] PREV_FUNCTION_COLUMN_TOUCH = 3'h7;
  localparam logic [2:0] PREV_FUNCTION_COLUMN_COL0 = 3'h6;
  // Reset values
  localparam logic [2:0] RST_NCOL = 3'h0;
  localparam logic [2:0] RST_PAD = 3'h0;
  localparam logic [2:0] RST_PREV_FUNCTION_COLUMN = 3'h0;
  localparam logic [1:0] RST_IRQ = 2'h0;
  // Slice timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SLICE_TIME_NS = 100000;
  localparam int SLICE_CYCLES = SLICE_TIME_NS / CLK_PERIOD_NS;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } tpts_wr_s;

  typedef enum logic [2:0] {
    SQ_IDLE = 3'b001,
    SQ_TOUCH = 3'b010,
    SQ_COLUMN = 3'b100
  } tpts_seq_e;
endpackage

// file: logic/tpts_slice_timer.sv
module tpts_slice_timer import tpts_pkg::*; #(
  parameter int CYCLES = SLICE_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Control and event
  input wire logic run,
  output logic sliceEnd
);
  generate
    if (CYCLES < 2 || CYCLES > 65535) begin : g_bad
      $error("tpts_slice_timer: CYCLES out of range");
    end
  endgenerate

  localparam logic [15:0] LAST = 16'(CYCLES - 1);
  logic [15:0] count_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 16'h0000;
      sliceEnd <= 1'b0;
    end else if (!run) begin
      count_q <= 16'h0000;
      sliceEnd <= 1'b0;
    end else if (count_q == LAST) begin
      count_q <= 16'h0000;
      sliceEnd <= 1'b1;
    end else begin
      count_q <= count_q + 16'h0001;
      sliceEnd <= 1'b0;
    end
  end
endmodule

// file: logic/tpts_axil_slave.sv
module tpts_axil_slave import tpts_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // AXI4-Lite
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side
  output tpts_wr_s wrReq,
  output logic wrValid,
  input wire logic wrErr,
  output logic [ADDR_W-1:0] rdAddr,
  input wire logic [31:0] rdData,
  input wire logic rdErr
);
  logic awHeld_q;
  logic wHeld_q;

  assign awready = !awHeld_q && !bvalid;
  assign wready = !wHeld_q && !bvalid;
  assign wrValid = awHeld_q && wHeld_q && !bvalid;
  assign arready = !rvalid;
  assign rdAddr = araddr;

  // Write address and data, taken in either order
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      wrReq <= '0;
    end else if (wrValid) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awHeld_q <= 1'b1;
        wrReq.addr <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_q <= 1'b1;
        wrReq.data <= wdata;
        wrReq.strb <= wstrb;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wrValid) begin
      bvalid <= 1'b1;
      bresp <= wrErr ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rdData;
      rresp <= rdErr ? RESP_SLVERR : RESP_OKAY;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

// file: bench/tpts_properties.sv
module tpts_properties import tpts_pkg::*; #(
  parameter int MAX_COLS = 7
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  // Slices
  input wire logic touchActive,
  input wire logic columnActive,
  input wire logic [2:0] activeColumn
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_resp_soon;
    ##[1:3] bvalid;
  endsequence
  sequence s_touch_to_col;
    $fell(touchActive) && columnActive;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> s_resp_soon)
    else $error("write response missing");
  a_write_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  a_resp_drop: assert property (bvalid && bready |=> !bvalid)
    else $error("write response not released");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  a_read_refuse: assert property (rvalid |-> !arready)
    else $error("read taken while data pending");
  a_read_drop: assert property (rvalid && rready |=> !rvalid)
    else $error("read data not released");
  a_first_column: assert property (s_touch_to_col |-> activeColumn == 3'h0)
    else $error("touch slice not followed by column 0");
  a_column_step: assert property (columnActive && $past(columnActive) &&
    activeColumn != $past(activeColumn) |-> activeColumn == $past(activeColumn) + 3'h1
    || activeColumn == 3'h0)
    else $error("column order broken");
  a_column_range: assert property (columnActive |-> int'(activeColumn) < MAX_COLS)
    else $error("column index out of range");
endmodule

bind tpts_touch_pad_turn_sequencer tpts_properties #(.MAX_COLS(MAX_COLS)) u_tpts_properties (
  .clock(clock), .reset_n(reset_n), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .touchActive(touchActive), .columnActive(columnActive), .activeColumn(activeColumn)
);

// file: bench/tpts_touch_pad_turn_sequencer_tb.sv
module tpts_touch_pad_turn_sequencer_tb import tpts_pkg::*; #(parameter int C = 8);
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, reset_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, touchActive, columnActive, irq;
  logic [7:0] awaddr, araddr, internalCompare;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, bx;
  logic [2:0] activeColumn, activePad;
  logic [7:0] cmpv [8];
  logic [7:0] regs [5] = '{OFS_CTRL, OFS_FUNC, OFS_ISTAT, OFS_IMASK, OFS_ICMP};
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  logic [10:0] tq[$];
  logic [65:0] rx;
  logic [10:0] tx;
  logic tPrev = 1'b0;
  int error_cnt = 0;
  int cmp_count = 0;
  int tcnt = 0;
  int n, k;

  tpts_touch_pad_turn_sequencer #(.CYCLES(C)) u_tpts_touch_pad_turn_sequencer (
    .clock(clock), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .touchActive(touchActive), .columnActive(columnActive), .activeColumn(activeColumn),
    .activePad(activePad), .internalCompare(internalCompare), .irq(irq)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tmo(input int i, input int b);
    if (i >= b) begin
      chk(i, 0);
      conclude();
    end
  endtask

  // Result watcher
  always @(posedge clock) begin
    if (rvalid && rready && rq.size() > 0) begin
      rx = rq.pop_front();
      chk(rdata & rx[63:32], rx[31:0]);
      chk({30'h0, rresp}, {30'h0, rx[65:64]});
    end
    if (bvalid && bready && bq.size() > 0) begin
      bx = bq.pop_front();
      chk({30'h0, bresp}, {30'h0, bx});
    end
    if (touchActive && !tPrev) begin
      tcnt++;
      if (tq.size() > 0) begin
        tx = tq.pop_front();
        chk({21'h0, activePad, internalCompare}, {21'h0, tx});
      end
    end
    tPrev = touchActive;
  end
  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = 1'b1;
    bq.push_back(r);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40 && (pa || pw); i++) begin
      @(posedge clock);
      if (awready) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (wready) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end
    tmo(i, 40);
    for (i = 0; i < 40 && !bvalid; i++) @(posedge clock);
    tmo(i, 40);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] r);
    int i;
    rq.push_back({r, m, e & m});
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clock);
      if (arready) break;
    end
    tmo(i, 40);
    arvalid <= 1'b0;
    for (i = 0; i < 40 && !rvalid; i++) @(posedge clock);
    tmo(i, 40);
    rready <= 1'b0;
  endtask

  task automatic waitv(input int s, input logic v);
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clock);
      if ((s == 0 ? touchActive : s == 1 ? columnActive : irq) === v) break;
    end
    tmo(i, 400);
  endtask

  task automatic rst;
    reset_n <= 1'b0;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
  endtask

  task automatic load;
    for (int i = 0; i < 8; i++) wr(OFS_CMP_BASE + 8'(4 * i), {24'h0, cmpv[i]}, RESP_OKAY);
    wr(OFS_IMASK, 32'h2, RESP_OKAY);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    void'($urandom(10));
    foreach (cmpv[i]) cmpv[i] = 8'($urandom());
    rst();
    foreach (regs[i]) rd(regs[i], 32'h0, 32'hFF, RESP_OKAY);
    rd(8'h40, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    wr(8'h44, 32'h1, RESP_SLVERR);
    load();
    for (int i = 0; i < 8; i++) rd(OFS_CMP_BASE + 8'(4 * i), {24'h0, cmpv[i]}, 32'hFF, RESP_OKAY);
    $display("test registers done");
    for (int c = 2; c > 0; c--) begin
      rst();
      load();
      for (n = 0; n < 10; n++) tq.push_back({3'(n), cmpv[(c > 1 || n == 0) ? n % 8 : (n - 1) % 8]});
      wr(OFS_CTRL, 32'h1 | (c << 4), RESP_OKAY);
      for (n = 0; n < 600 && tq.size() > 0; n++) @(posedge clock);
      tmo(n, 600);
      if (c == 2) begin
        waitv(0, 1'b0);
        waitv(0, 1'b1);
        rd(OFS_FUNC, 32'h50, 32'h70, RESP_OKAY);
        waitv(1, 1'b1);
        rd(OFS_FUNC, 32'h70, 32'h70, RESP_OKAY);
        repeat (C) @(posedge clock);
        rd(OFS_FUNC, 32'h60, 32'h70, RESP_OKAY);
        wr(OFS_ISTAT, 32'h3, RESP_OKAY);
        waitv(2, 1'b0);
        waitv(2, 1'b1);
        repeat (2) @(posedge clock);
        rd(OFS_FUNC, 32'((tcnt - 1) % 8), 32'h7, RESP_OKAY);
      end
      $display("test hardware turn with %0d columns done", c);
    end
    rst();
    load();
    repeat (3) tq.push_back({3'h5, cmpv[5]});
    wr(OFS_CTRL, 32'h12, RESP_OKAY);
    wr(OFS_FUNC, 32'h5, RESP_OKAY);
    wr(OFS_CTRL, 32'h13, RESP_OKAY);
    for (n = 0; n < 600 && tq.size() > 0; n++) @(posedge clock);
    tmo(n, 600);
    $display("test software turn done");
    rst();
    load();
    wr(OFS_IMASK, 32'h0, RESP_OKAY);
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    for (n = 0; n < 100 && activePad !== 3'h1; n++) @(posedge clock);
    k = n;
    for (n = 0; n < 100 && activePad !== 3'h2; n++) @(posedge clock);
    // Enable lands one edge before wr returns; slices of C+1 and C, then output flop
    chk(k, 2 * C + 3);
    chk(n, C);
    chk({31'h0, irq}, 32'h0);
    rd(OFS_ISTAT, 32'h3, 32'h3, RESP_OKAY);
    wr(OFS_IMASK, 32'h1, RESP_OKAY);
    waitv(2, 1'b1);
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    repeat (2 * C) @(posedge clock);
    wr(OFS_ISTAT, 32'h3, RESP_OKAY);
    rd(OFS_ISTAT, 32'h0, 32'h3, RESP_OKAY);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    $display("test no columns and interrupts done");
    conclude();
  end
endmodule
